// ### common/dccr_defines.svh
// register offsets, field positions, reset values and timing for the converter clock control
`ifndef DCCR_DEFINES_SVH
`define DCCR_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets on the special-function-register bus
// ----------------------------------------------------------------
`define DCCR_CONVERTER_CLOCK_CONFIG_ADDR 8'h96
`define DCCR_REGULATOR_CONTROL_ADDR      8'hC9

// ----------------------------------------------------------------
// converter_clock_config fields
// ----------------------------------------------------------------
`define DCCR_CFG_SOURCE_BIT   0
`define DCCR_CFG_SLEEP_BIT    1
`define DCCR_CFG_PEAK_BIT     2
`define DCCR_CFG_INVERT_BIT   3
`define DCCR_CFG_SARINV_BIT   4
`define DCCR_CFG_DIV_LSB      5
`define DCCR_CFG_DIV_MSB      6
`define DCCR_CFG_RESERVED_BIT 7
`define DCCR_CFG_RESET        7'h00

// ----------------------------------------------------------------
// regulator_control fields
// ----------------------------------------------------------------
`define DCCR_REG_BIAS_BIT     4
`define DCCR_REG_RESET        8'h10

// ----------------------------------------------------------------
// timing: bias settle time and clock rate
// ----------------------------------------------------------------
`define DCCR_BIAS_SETTLE_NS   4000
`define DCCR_CLK_MHZ          250
`define DCCR_BIAS_SETTLE_CYC  ((`DCCR_BIAS_SETTLE_NS * `DCCR_CLK_MHZ + 999) / 1000)

`endif

// ### common/dccr_pkg.sv
// types shared by the converter clock control modules
package dccr_pkg;

   // ----------------------------------------------------------------
   // converter_clock_config contents, bits 6 down to 0
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] converter_clock_divide_select;  // 00 /1, 01 /2, 10 /4, 11 /8
      logic       sar_clock_invert_on_lock;       // 0 inverts sar clock under lock
      logic       converter_input_clock_invert;   // invert request, carried to the generator but never applied
      logic       peak_current_threshold_select;  // 0 low, 1 high
      logic       sleep_rail_connect_select;      // 0 battery, 1 floating
      logic       converter_clock_source_select;  // 0 local osc, 1 system clock
   } dccr_conv_cfg_t;

   // ----------------------------------------------------------------
   // clock path settings used by the clock generator
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       converter_clock_source_select;
      logic       converter_input_clock_invert;
      logic [1:0] converter_clock_divide_select;
   } dccr_clk_cfg_t;

   // clock generator states, one-hot
   typedef enum logic [2:0] {
      DCCR_ST_RUN   = 3'b001,  // settings stable
      DCCR_ST_DRAIN = 3'b010,  // finish the current period
      DCCR_ST_LOAD  = 3'b100   // take new settings at the boundary
   } dccr_cg_state_t;

   // clock generator state
   typedef struct packed {
      dccr_cg_state_t fsm;
      dccr_clk_cfg_t  act;
      logic [2:0]     cnt;
      logic           tick;
   } dccr_cg_reg_t;

   // top level state
   typedef struct packed {
      dccr_conv_cfg_t cfg;
      logic           bias_force;
      logic [7:0]     rdata;
      logic [1:0]     osc_sync;
      logic           osc_prev;
      logic [9:0]     settle_cnt;
      logic           bias_ready;
      logic           bias_on;
      logic           reg_en;
      logic           rail_bat;
      logic           rail_float;
      logic           peak_high;
      logic           sar_tick;
      logic           sar_inv;
      logic           sar_lock;
      logic           track_en;
   } dccr_top_reg_t;

   // last count value of a divide-by-2^sel period
   function automatic logic [2:0] dccr_div_last(input logic [1:0] sel);
      logic [3:0] n;
      n = 4'h1 << sel;
      return 3'(n - 4'h1);
   endfunction

endpackage

// ### rtl/dccr_clk_gen.sv
// converter clock generator: source select, divider and boundary-aligned switching
`timescale 1ns/1ps
`include "dccr_defines.svh"

module dccr_clk_gen
   import dccr_pkg::*;
(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic          ce,
   // requested settings and local oscillator edge
   input  wire dccr_clk_cfg_t cfg_req,
   input  wire logic          osc_edge,
   // generated converter clock
   output      logic          tick,
   output      dccr_clk_cfg_t cfg_act
);

   dccr_cg_reg_t r;       // registered state
   dccr_cg_reg_t next_r;  // next state
   logic         tick_now;

   // ----------------------------------------------------------------
   // next state: tick per period, settings change only at a boundary
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;
      // system clock path counts cycles, otherwise follow the oscillator
      if (r.act.converter_clock_source_select) begin
         tick_now = (r.cnt == dccr_div_last(r.act.converter_clock_divide_select));
      end else begin
         tick_now = osc_edge;
      end
      next_r.tick = 1'b0;
      case (r.fsm)
         DCCR_ST_RUN: begin
            next_r.tick = tick_now;
            next_r.cnt  = tick_now ? 3'h0 : 3'(r.cnt + 3'h1);
            if (cfg_req != r.act) begin
               next_r.fsm = DCCR_ST_DRAIN;
            end
         end
         DCCR_ST_DRAIN: begin
            // let the running period end before switching
            next_r.tick = tick_now;
            next_r.cnt  = tick_now ? 3'h0 : 3'(r.cnt + 3'h1);
            if (tick_now) begin
               next_r.fsm = DCCR_ST_LOAD;
            end
         end
         DCCR_ST_LOAD: begin
            // new settings start a fresh period
            next_r.act = cfg_req;
            next_r.cnt = 3'h0;
            next_r.fsm = DCCR_ST_RUN;
         end
         default: begin
            next_r.fsm = DCCR_ST_RUN;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register, frozen while ce is low
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '{fsm: DCCR_ST_RUN, act: '0, cnt: 3'h0, tick: 1'b0};
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign tick    = r.tick;
   assign cfg_act = r.act;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   div_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && r.fsm != DCCR_ST_LOAD && r.act.converter_clock_source_select
       && r.cnt != dccr_div_last(r.act.converter_clock_divide_select)) |=> !tick)
      else $error("converter tick outside divider boundary");

   osc_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && r.fsm != DCCR_ST_LOAD && !r.act.converter_clock_source_select) |=> (tick == $past(osc_edge)))
      else $error("local oscillator tick mismatch");

   switch_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
      (r.act != $past(r.act)) |-> ($past(r.fsm) == DCCR_ST_LOAD))
      else $error("clock settings changed inside a period");

endmodule

// ### rtl/dccr_top.sv
// converter clock and regulator control: registers, clock path, sleep and bias outputs
// Operation
// - system clock source divides by 1/2/4/8
// - divider ignored on local oscillator
// - source bit picks oscillator or system clock
// - invert bit stored and passed on, not applied to the clock path
// - under lock sar clock inverted when bit 0
// - sar invert bit ignored without lock
// - peak threshold bit drives analog stage
// - sleep rail: battery when 0, floating when 1
// - config top bit reads zero, write zero
// - bias bit forces oscillator bias on
// - regulator off in sleep, on in suspend
// - control bits 3:1 and 7 read zero
// - reserved control bits read zero, write zero
// - locked sar tracks in quiet interval
`timescale 1ns/1ps
`include "dccr_defines.svh"

module dccr_top
   import dccr_pkg::*;
#(
   parameter int SETTLE_CYCLES = `DCCR_BIAS_SETTLE_CYC  // bias settle time in clocks
)
(
   // clock, reset, enable
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic          ce,

   // register port
   input  wire logic [7:0]    sfr_addr,
   input  wire logic          sfr_wr,
   input  wire logic          sfr_rd,
   input  wire logic [7:0]    sfr_wdata,
   output      logic [7:0]    sfr_rdata,

   // system state, same clock domain
   input  wire logic          sync_enable,
   input  wire logic          converter_enable,
   input  wire logic          sleep_mode,
   input  wire logic          suspend_mode,
   input  wire logic          osc_in_use,
   input  wire logic          quiet_interval,

   // local oscillator pin, asynchronous
   input  wire logic          local_osc_in,

   // converter clock
   output      logic          conv_clk_tick,
   output      dccr_clk_cfg_t conv_clk_active,

   // analog sampler clocking
   output      logic          sar_clk_tick,
   output      logic          sar_clk_invert,
   output      logic          sar_lock,
   output      logic          adc_track_en,

   // analog controls
   output      logic          peak_current_high,
   output      logic          rail_battery,
   output      logic          rail_float,
   output      logic          regulator_enable,
   output      logic          osc_bias_on,
   output      logic          osc_bias_ready
);

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 1023) begin : g_bad_settle
      $error("SETTLE_CYCLES must be 1 to 1023");
   end

   // last settle count before ready
   localparam logic [9:0] SETTLE_LAST = 10'(SETTLE_CYCLES - 1);

   dccr_top_reg_t  r;         // registered state
   dccr_top_reg_t  next_r;    // next state
   dccr_clk_cfg_t  clk_req;   // requested clock path settings
   logic           gen_tick;  // converter tick from generator
   logic           osc_edge;  // rising edge of the local oscillator
   logic           cfg_wr;    // write to converter_clock_config
   logic           reg_wr;    // write to regulator_control
   logic           cfg_rd;    // read of converter_clock_config
   logic           reg_rd;    // read of regulator_control

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   assign cfg_wr = sfr_wr && (sfr_addr == `DCCR_CONVERTER_CLOCK_CONFIG_ADDR);
   assign reg_wr = sfr_wr && (sfr_addr == `DCCR_REGULATOR_CONTROL_ADDR);

   // read strobes
   assign cfg_rd = sfr_rd && (sfr_addr == `DCCR_CONVERTER_CLOCK_CONFIG_ADDR);
   assign reg_rd = sfr_rd && (sfr_addr == `DCCR_REGULATOR_CONTROL_ADDR);

   // edge seen on the second synchroniser stage only
   assign osc_edge = r.osc_sync[1] && !r.osc_prev;

   // clock path request straight from the register
   assign clk_req.converter_clock_source_select = r.cfg.converter_clock_source_select;
   assign clk_req.converter_input_clock_invert  = r.cfg.converter_input_clock_invert;
   assign clk_req.converter_clock_divide_select = r.cfg.converter_clock_divide_select;

   // ----------------------------------------------------------------
   // clock generator
   // ----------------------------------------------------------------
   // settings switch only at a period end
   dccr_clk_gen u_clk_gen (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .cfg_req (clk_req),
      .osc_edge(osc_edge),
      .tick    (gen_tick),
      .cfg_act (conv_clk_active)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;

      // two-stage synchroniser and edge history
      next_r.osc_sync = {r.osc_sync[0], local_osc_in};
      next_r.osc_prev = r.osc_sync[1];

      // register writes; top config bit is never stored
      if (cfg_wr) begin
         // low seven bits are stored
         next_r.cfg = dccr_conv_cfg_t'(sfr_wdata[`DCCR_CFG_DIV_MSB:0]);
      end
      // only the bias bit is kept, unused and reserved bits are dropped
      if (reg_wr) begin
         // bias bit only
         next_r.bias_force = sfr_wdata[`DCCR_REG_BIAS_BIT];
      end

      // read data, registered, unmapped reads give zero
      if (cfg_rd) begin
         // top bit forced low
         next_r.rdata = {1'b0, r.cfg};
      end else if (reg_rd) begin
         // bias bit, rest zero
         next_r.rdata = 8'h00;
         next_r.rdata[`DCCR_REG_BIAS_BIT] = r.bias_force;
      end else if (sfr_rd) begin
         // unmapped address
         next_r.rdata = 8'h00;
      end

      // analog controls follow the new register contents
      next_r.peak_high  = next_r.cfg.peak_current_threshold_select;

      // sleep rail only while enabled and asleep
      next_r.rail_bat   = converter_enable && sleep_mode
                          && !next_r.cfg.sleep_rail_connect_select;
      next_r.rail_float = converter_enable && sleep_mode
                          && next_r.cfg.sleep_rail_connect_select;

      // regulator off only in sleep, suspend keeps it on
      next_r.reg_en = !sleep_mode;

      // bias forced on, or on while the oscillator needs it
      next_r.bias_on = next_r.bias_force || osc_in_use;

      // settle timer restarts whenever the bias turns on
      if (!next_r.bias_on) begin
         // bias off, never ready
         next_r.settle_cnt = 10'h000;
         next_r.bias_ready = 1'b0;
      end else if (!r.bias_on) begin
         // turn-on edge restarts the count
         next_r.settle_cnt = 10'h000;
         next_r.bias_ready = 1'b0;
      end else if (!r.bias_ready) begin
         // settling, ready on the last count
         next_r.settle_cnt = 10'(r.settle_cnt + 10'h001);
         next_r.bias_ready = (r.settle_cnt == SETTLE_LAST);
      end

      // sampler clocking locked to the converter only under sync
      next_r.sar_lock = sync_enable;
      // sampler tick one cycle behind the converter
      next_r.sar_tick = sync_enable && gen_tick;
      // invert bit only counts under lock
      next_r.sar_inv  = sync_enable && !next_r.cfg.sar_clock_invert_on_lock;
      // tracking free when not locked
      next_r.track_en = sync_enable ? quiet_interval : 1'b1;
   end

   // ----------------------------------------------------------------
   // state register, frozen while ce is low
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         // register reset values
         r            <= '0;
         r.cfg        <= dccr_conv_cfg_t'(`DCCR_CFG_RESET);
         r.bias_force <= 1'b1;
         r.bias_on    <= 1'b1;
         r.reg_en     <= 1'b1;
         r.track_en   <= 1'b1;
      end else if (ce) begin
         // all state holds while ce is low
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------------------------------
   assign sfr_rdata         = r.rdata;

   // converter tick is already a flop
   assign conv_clk_tick     = gen_tick;

   // sampler clocking
   assign sar_clk_tick      = r.sar_tick;
   assign sar_clk_invert    = r.sar_inv;
   assign sar_lock          = r.sar_lock;
   assign adc_track_en      = r.track_en;

   // analog controls
   assign peak_current_high = r.peak_high;
   assign rail_battery      = r.rail_bat;
   assign rail_float        = r.rail_float;
   assign regulator_enable  = r.reg_en;
   assign osc_bias_on       = r.bias_on;
   assign osc_bias_ready    = r.bias_ready;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   reg_sleep_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && sleep_mode) |=> !regulator_enable)
      else $error("regulator on during sleep");

   reg_suspend_on_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && !sleep_mode && suspend_mode) |=> regulator_enable)
      else $error("regulator off during suspend");

   cfg_top_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && cfg_rd) |=> (sfr_rdata == {1'b0, $past(r.cfg)}))
      else $error("config read data wrong");

   ctl_unused_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && reg_rd) |=> (sfr_rdata[3:1] == 3'h0 && !sfr_rdata[7]))
      else $error("unused control bits not zero");

   ctl_reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && reg_rd) |=> (sfr_rdata[6:5] == 2'h0 && !sfr_rdata[0]))
      else $error("reserved control bits not zero");

   peak_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && cfg_wr) |=> (peak_current_high == $past(sfr_wdata[`DCCR_CFG_PEAK_BIT])))
      else $error("peak threshold select not applied");

   rail_select_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && !cfg_wr && converter_enable && sleep_mode)
      |=> (rail_float == $past(r.cfg.sleep_rail_connect_select)) && (rail_battery != rail_float))
      else $error("sleep rail connection wrong");

   sar_inv_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && !cfg_wr && sync_enable) |=> (sar_clk_invert == !$past(r.cfg.sar_clock_invert_on_lock)))
      else $error("sar clock inversion wrong under lock");

   sar_inv_free_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && !sync_enable) |=> !sar_clk_invert && !sar_clk_tick)
      else $error("sar invert active without lock");

   bias_force_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && !reg_wr && r.bias_force) |=> osc_bias_on)
      else $error("bias off while forced");

   bias_settle_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && !r.bias_on && next_r.bias_on) ##1 ce |=> !osc_bias_ready)
      else $error("bias ready before settle time");

   track_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && sync_enable) |=> (adc_track_en == $past(quiet_interval)))
      else $error("tracking window not locked to quiet time");

   sar_tick_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && sync_enable) |=> (sar_clk_tick == $past(gen_tick)))
      else $error("sampler tick not locked to converter tick");

   sar_lock_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
      ce |=> (sar_lock == $past(sync_enable)))
      else $error("sampler lock does not follow sync");

   rail_awake_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && !(converter_enable && sleep_mode)) |=> (!rail_battery && !rail_float))
      else $error("sleep rail switched while awake");

   bias_ready_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !osc_bias_on |-> !osc_bias_ready)
      else $error("bias ready while bias off");

endmodule

// ### tb/tb_top.sv
// self-checking testbench for the converter clock and regulator control block
`timescale 1ns/1ps

module tb_top
   import dccr_pkg::*;
;
   // ----------------------------------------------------------------
   // signals and counters
   // ----------------------------------------------------------------
   localparam int    SETTLE = 4;       // shortened bias settle count
   logic             clk;              // system clock
   logic             reset_n;          // async reset, active low
   logic [7:0]       sfr_addr;         // register address
   logic             sfr_wr;           // write strobe
   logic             sfr_rd;           // read strobe
   logic [7:0]       sfr_wdata;        // write data
   logic [7:0]       sfr_rdata;        // read data
   logic             sync_enable;      // sampler lock request
   logic             converter_enable; // converter running
   logic             sleep_mode;       // device asleep
   logic             suspend_mode;     // device suspended
   logic             osc_in_use;       // precision oscillator busy
   logic             quiet_interval;   // converter quiet time
   logic             local_osc_in;     // local oscillator pin
   logic             conv_clk_tick;    // converter tick
   dccr_clk_cfg_t    conv_clk_active;  // settings in force
   logic             sar_clk_tick;     // sampler tick
   logic             sar_clk_invert;   // sampler clock inversion
   logic             sar_lock;         // sampler locked
   logic             adc_track_en;     // sampler tracking window
   logic             peak_current_high;
   logic             rail_battery;
   logic             rail_float;
   logic             regulator_enable;
   logic             osc_bias_on;
   logic             osc_bias_ready;
   int               n_fail;           // mismatches seen
   int               checks;           // comparisons made
   int               gap;              // measured tick spacing
   int               d;                // divider loop index

   // ----------------------------------------------------------------
   // design under test
   // ----------------------------------------------------------------
   dccr_top #(.SETTLE_CYCLES(SETTLE)) DUT (
      .clk(clk), .reset_n(reset_n), .ce(1'b1),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .sync_enable(sync_enable), .converter_enable(converter_enable), .sleep_mode(sleep_mode),
      .suspend_mode(suspend_mode), .osc_in_use(osc_in_use), .quiet_interval(quiet_interval),
      .local_osc_in(local_osc_in), .conv_clk_tick(conv_clk_tick), .conv_clk_active(conv_clk_active),
      .sar_clk_tick(sar_clk_tick), .sar_clk_invert(sar_clk_invert), .sar_lock(sar_lock),
      .adc_track_en(adc_track_en), .peak_current_high(peak_current_high), .rail_battery(rail_battery),
      .rail_float(rail_float), .regulator_enable(regulator_enable), .osc_bias_on(osc_bias_on),
      .osc_bias_ready(osc_bias_ready));

   // ----------------------------------------------------------------
   // clock and local oscillator
   // ----------------------------------------------------------------
   // 250 MHz system clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // local oscillator: free running, rising edge every 20 system clocks
   always begin
      repeat (10) @(negedge clk);
      local_osc_in = ~local_osc_in;
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one register write, strobe held over one rising edge
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      sfr_addr  = a;
      sfr_wdata = v;
      sfr_wr    = 1'b1;
      @(negedge clk);
      sfr_wr    = 1'b0;
   endtask

   // one register read, data held until the next read
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd   = 1'b1;
      @(negedge clk);
      sfr_rd   = 1'b0;
      @(negedge clk);
      v = sfr_rdata;
   endtask

   // read and compare
   task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      sfr_read(a, v);
      check(v, exp);
   endtask

   // let level inputs propagate
   task automatic settle();
      repeat (3) @(negedge clk);
   endtask

   // cycles between two converter ticks, bounded
   task automatic tick_gap(output int n);
      int i;
      n = 0;
      for (i = 0; i < 100 && conv_clk_tick !== 1'b1; i++) @(negedge clk);
      do begin
         @(negedge clk);
         n++;
      end while (conv_clk_tick !== 1'b1 && n < 100);
   endtask

   // verdict and end of run
   task automatic stop_test();
      if (n_fail == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // watchdog: tests need well under 3000 cycles
   // ----------------------------------------------------------------
   initial begin
      #(20000 * 4);
      n_fail++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      reset_n = 1'b0; sfr_addr = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_wdata = 8'h00;
      sync_enable = 1'b0; converter_enable = 1'b0; sleep_mode = 1'b0; suspend_mode = 1'b0;
      osc_in_use = 1'b0; quiet_interval = 1'b0; local_osc_in = 1'b0;
      n_fail = 0; checks = 0;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      // reset values and reserved bits
      read_check(8'h96, 8'h00);
      read_check(8'hC9, 8'h10);
      check({7'h00, regulator_enable}, 8'h01);
      sfr_write(8'h96, 8'h7F);
      read_check(8'h96, 8'h7F);
      sfr_write(8'hC9, 8'h8E);
      read_check(8'hC9, 8'h00);
      sfr_write(8'h55, 8'hFF);
      read_check(8'h55, 8'h00);
      // bias off, then forced on with settle count
      settle();
      check({6'h00, osc_bias_on, osc_bias_ready}, 8'h00);
      sfr_write(8'hC9, 8'h9E);
      read_check(8'hC9, 8'h10);
      check({7'h00, osc_bias_ready}, 8'h00);
      repeat (SETTLE + 4) @(negedge clk);
      check({6'h00, osc_bias_on, osc_bias_ready}, 8'h03);
      // peak threshold and sleep rail
      sfr_write(8'h96, 8'h04);
      converter_enable = 1'b1;
      sleep_mode = 1'b1;
      settle();
      check({5'h00, peak_current_high, rail_battery, rail_float}, 8'h06);
      check({7'h00, regulator_enable}, 8'h00);
      sfr_write(8'h96, 8'h02);
      settle();
      check({5'h00, peak_current_high, rail_battery, rail_float}, 8'h01);
      sleep_mode = 1'b0;
      suspend_mode = 1'b1;
      settle();
      check({6'h00, rail_float, regulator_enable}, 8'h01);
      // sampler inversion only under lock
      sfr_write(8'h96, 8'h00);
      settle();
      check({6'h00, sar_clk_invert, sar_lock}, 8'h00);
      sync_enable = 1'b1;
      quiet_interval = 1'b0;
      settle();
      check({5'h00, sar_clk_invert, sar_lock, adc_track_en}, 8'h06);
      quiet_interval = 1'b1;
      sfr_write(8'h96, 8'h10);
      settle();
      check({5'h00, sar_clk_invert, sar_lock, adc_track_en}, 8'h03);
      // system clock source, every divider, invert on odd settings
      for (d = 0; d < 4; d++) begin
         sfr_write(8'h96, {1'b0, 2'(d), 1'b1, d[0], 3'b001});
         repeat (30) @(negedge clk);
         check({4'h0, conv_clk_active}, {4'h0, 1'b1, d[0], 2'(d)});
         tick_gap(gap);
         check(8'(gap), 8'(1 << d));
      end
      // sampler tick follows converter tick under lock
      tick_gap(gap);
      @(negedge clk);
      check({7'h00, sar_clk_tick}, 8'h01);
      sync_enable = 1'b0;
      settle();
      sfr_write(8'h96, 8'h00);
      settle();
      check({7'h00, sar_clk_invert}, 8'h00);
      // local oscillator source ignores the divider
      sfr_write(8'h96, 8'h60);
      repeat (80) @(negedge clk);
      check({4'h0, conv_clk_active.converter_clock_source_select, 3'h0}, 8'h00);
      tick_gap(gap);
      tick_gap(gap);
      check(8'(gap), 8'h14);
      // back to system clock, divide by 2
      sfr_write(8'h96, 8'h21);
      repeat (60) @(negedge clk);
      tick_gap(gap);
      check(8'(gap), 8'h02);
      stop_test();
   end
endmodule
